/* src/pisc_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pisc_cfg.svh"

// What this block does
// RULE1: polarity bit 1 idles pin high, asserts low; bit 0 inverts that.
// RULE2: test bit set forces interrupt on the pin while it stays set; resets 0.
// RULE3: status bit 15 latches on link quality change while link is up.
// RULE4: status bit 14 latches on any change of energy detect state.
// RULE5: status bit 13 latches on any change of link status.
// RULE6: status bit 12 latches when a wake frame is detected.
// RULE7: status bit 11 latches on an electrostatic discharge event.
// RULE8: status bit 10 latches when master/slave training completes.
// RULE9: status bit 9 latches when false-carrier counter passes half range.
// RULE10: status bit 8 latches when receive-error counter passes half range.
// RULE11: enable bits 7..0 default 0, gate status bits 15..8 in order.
// RULE12: false-carrier counter flags half-full above 0x7F, saturates at 0xFF.
// RULE13: pin asserted while any enabled status bit is set or test bit set.
// RULE14: status bits hold until read; read clears unless event still present.
module pisc_top
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire pisc_pkg::pisc_evt_t evt_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic int_pin_o,
  output logic irq_o
);

  import pisc_pkg::*;

  // byte-lane merge for the 16-bit registers
  function automatic logic [15:0] pisc_merge16
  (
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0] strb
  );
    logic [15:0] res;
    res = old;
    if (strb[0])
    begin
      res[7:0] = wd[7:0];
    end
    if (strb[1])
    begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction : pisc_merge16

  // one aligned word per register index
  function automatic logic pisc_hit
  (
    input logic [7:0] addr,
    input logic [5:0] index
  );
    return (addr[1:0] == 2'b00) & (addr[7:2] == index);
  endfunction : pisc_hit

  // level change against the previous cycle's sample
  function automatic logic pisc_changed
  (
    input logic now_v,
    input logic last_v
  );
    return now_v ^ last_v;
  endfunction : pisc_changed

  pisc_apb_st_t apb_st;
  pisc_apb_st_t next_apb_st;
  logic [15:0] test_reg;
  logic [7:0] stat;
  logic [7:0] en;
  logic [7:0] stat_snap;
  logic fc_snap_valid;
  logic [7:0] irq_stat;
  logic [7:0] irq_mask;
  logic link_up_q;
  logic link_quality_q;
  logic energy_det_q;

  wire logic hit_test;
  wire logic hit_stat1;
  wire logic hit_fc;
  wire logic hit_irq_stat;
  wire logic hit_irq_mask;
  wire logic mapped;
  wire logic access;
  wire logic capture;
  wire logic done;
  wire logic wr_done;
  wire logic rd_done;
  wire logic wr_test;
  wire logic wr_stat1;
  wire logic wr_irq_stat;
  wire logic wr_irq_mask;
  wire logic rd_stat1;
  wire logic rd_fc;
  wire logic [31:0] rd_word;
  wire logic [7:0] fc_count;
  wire logic fc_half;
  wire logic fc_clr;
  wire logic [7:0] ev_set;
  wire logic [7:0] stat_clr;
  wire logic [7:0] irq_clr;
  wire logic [7:0] next_stat;
  wire logic [7:0] next_irq_stat;
  wire logic [15:0] next_test;
  wire logic [15:0] next_en;
  wire logic [15:0] next_irq_mask;
  wire logic int_active;
  wire logic polarity;
  wire logic test_force;

  // address decode
  assign hit_test = pisc_hit(paddr_i, `PISC_IDX_TEST);
  assign hit_stat1 = pisc_hit(paddr_i, `PISC_IDX_STAT1);
  assign hit_fc = pisc_hit(paddr_i, `PISC_IDX_FC);
  assign hit_irq_stat = pisc_hit(paddr_i, `PISC_IDX_IRQ_STAT);
  assign hit_irq_mask = pisc_hit(paddr_i, `PISC_IDX_IRQ_MASK);
  assign mapped = hit_test | hit_stat1 | hit_fc | hit_irq_stat | hit_irq_mask;

  // one wait state: answer registered at the first access edge
  assign access = psel_i & penable_i;
  assign capture = access & (apb_st == PISC_IDLE);
  assign done = access & (apb_st == PISC_RESP);
  assign wr_done = done & pwrite_i & mapped;
  assign rd_done = done & ~pwrite_i & mapped;
  assign wr_test = wr_done & hit_test;
  assign wr_stat1 = wr_done & hit_stat1;
  assign wr_irq_stat = wr_done & hit_irq_stat;
  assign wr_irq_mask = wr_done & hit_irq_mask;
  assign rd_stat1 = rd_done & hit_stat1;
  assign rd_fc = rd_done & hit_fc;

  // read mux
  assign rd_word = hit_test ? {16'h0000, test_reg} :
                   hit_stat1 ? {16'h0000, stat, en} :
                   hit_fc ? {24'h000000, fc_count} :
                   hit_irq_stat ? {24'h000000, irq_stat} :
                   hit_irq_mask ? {24'h000000, irq_mask} :
                   32'h00000000;

  always_comb
  begin
    next_apb_st = apb_st;
    case (apb_st)
      PISC_IDLE:
      begin
        if (access)
        begin
          next_apb_st = PISC_RESP;
        end
      end
      PISC_RESP:
      begin
        next_apb_st = PISC_IDLE;
      end
      default:
      begin
        next_apb_st = PISC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      apb_st <= PISC_IDLE;
    end
    else
    begin
      apb_st <= next_apb_st;
    end
  end

  // answer registered so the bus outputs come from flops
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end
    else
    begin
      pready_o <= capture;
      pslverr_o <= capture & ~mapped;
      if (capture)
      begin
        prdata_o <= pwrite_i ? 32'h00000000 : rd_word;
      end
    end
  end

  // false-carrier counter, cleared by reading it
  assign fc_clr = rd_fc & fc_snap_valid;

  pisc_fc_cnt u_fc_cnt
  (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .inc_i(evt_i.false_carrier_event),
    .clr_i(fc_clr),
    .count_o(fc_count),
    .half_o(fc_half)
  );

  // event detection
  assign ev_set[`PISC_EV_LINK_QUALITY] = evt_i.link_up & pisc_changed(evt_i.link_quality, link_quality_q); // RULE3
  assign ev_set[`PISC_EV_ENERGY] = pisc_changed(evt_i.energy_det, energy_det_q); // RULE4
  assign ev_set[`PISC_EV_LINK_STATUS] = pisc_changed(evt_i.link_up, link_up_q); // RULE5
  assign ev_set[`PISC_EV_WAKE] = evt_i.wake_frame_detect; // RULE6
  assign ev_set[`PISC_EV_ESD] = evt_i.esd_event; // RULE7
  assign ev_set[`PISC_EV_TRAINING] = evt_i.training_done; // RULE8
  assign ev_set[`PISC_EV_FC_HALF] = fc_half; // RULE9
  assign ev_set[`PISC_EV_RXERR_HALF] = evt_i.rx_error_half_full; // RULE10

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      link_up_q <= 1'b0;
      link_quality_q <= 1'b0;
      energy_det_q <= 1'b0;
    end
    else
    begin
      link_up_q <= evt_i.link_up;
      link_quality_q <= evt_i.link_quality;
      energy_det_q <= evt_i.energy_det;
    end
  end

  // only bits that were shown to software are cleared; new events win
  assign stat_clr = rd_stat1 ? stat_snap : 8'h00; // RULE14
  assign next_stat = ev_set | (stat & ~stat_clr); // RULE14

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      stat <= `PISC_STAT_RST;
    end
    else
    begin
      stat <= next_stat;
    end
  end

  // what software was shown decides what its read clears
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      stat_snap <= 8'h00;
      fc_snap_valid <= 1'b0;
    end
    else if (capture)
    begin
      stat_snap <= (hit_stat1 & ~pwrite_i) ? stat : 8'h00;
      fc_snap_valid <= hit_fc & ~pwrite_i;
    end
  end

  // writable registers
  assign next_test = wr_test ? pisc_merge16(test_reg, pwdata_i, pstrb_i) : test_reg; // RULE2
  assign next_en = wr_stat1 ? pisc_merge16({8'h00, en}, pwdata_i, pstrb_i) : {8'h00, en}; // RULE11
  assign next_irq_mask = wr_irq_mask ?
                         pisc_merge16({8'h00, irq_mask}, pwdata_i, pstrb_i) : {8'h00, irq_mask};

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      test_reg <= `PISC_TEST_RST;
      en <= `PISC_EN_RST;
      irq_mask <= `PISC_IRQ_MASK_RST;
    end
    else
    begin
      test_reg <= next_test;
      en <= next_en[7:0];
      irq_mask <= next_irq_mask[7:0];
    end
  end

  // system interrupt: sticky, write one to clear, set wins
  assign irq_clr = (wr_irq_stat & pstrb_i[0]) ? pwdata_i[7:0] : 8'h00;
  assign next_irq_stat = ev_set | (irq_stat & ~irq_clr);

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      irq_stat <= 8'h00;
    end
    else
    begin
      irq_stat <= next_irq_stat;
    end
  end

  // level output, one cycle behind the sticky bits
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // interrupt pin
  assign polarity = test_reg[`PISC_POL_BIT];
  assign test_force = test_reg[`PISC_TEST_BIT];
  assign int_active = (|(stat & en)) | test_force; // RULE13 RULE11 RULE2

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      int_pin_o <= 1'b1;
    end
    else
    begin
      int_pin_o <= polarity ? ~int_active : int_active; // RULE1
    end
  end

endmodule : pisc_top
`default_nettype wire

/* src/pisc_cfg.svh */
`ifndef PISC_CFG_SVH
`define PISC_CFG_SVH

// register indices; byte address is four times the index
`define PISC_IDX_TEST 6'h11
`define PISC_IDX_STAT1 6'h12
`define PISC_IDX_FC 6'h14
`define PISC_IDX_IRQ_STAT 6'h18
`define PISC_IDX_IRQ_MASK 6'h19

// test and polarity register
`define PISC_TEST_RST 16'h010B
`define PISC_POL_BIT 3
`define PISC_TEST_BIT 2

// status and enable halves of the first status register
`define PISC_STAT_LSB 8
`define PISC_STAT_RST 8'h00
`define PISC_EN_RST 8'h00
`define PISC_IRQ_MASK_RST 8'h00

// event positions inside the 8-bit status vector
`define PISC_EV_LINK_QUALITY 7
`define PISC_EV_ENERGY 6
`define PISC_EV_LINK_STATUS 5
`define PISC_EV_WAKE 4
`define PISC_EV_ESD 3
`define PISC_EV_TRAINING 2
`define PISC_EV_FC_HALF 1
`define PISC_EV_RXERR_HALF 0

// false-carrier counter limits
`define PISC_FC_HALF 8'h7F
`define PISC_FC_MAX 8'hFF
`define PISC_FC_RST 8'h00

`endif

/* src/pisc_pkg.sv */
package pisc_pkg;

  typedef struct packed
  {
    logic link_up;
    logic link_quality;
    logic energy_det;
    logic wake_frame_detect;
    logic esd_event;
    logic training_done;
    logic false_carrier_event;
    logic rx_error_half_full;
  } pisc_evt_t;

  typedef enum logic [0:0]
  {
    PISC_IDLE = 1'b0,
    PISC_RESP = 1'b1
  } pisc_apb_st_t;

endpackage : pisc_pkg

/* src/pisc_fc_cnt.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pisc_cfg.svh"

module pisc_fc_cnt
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic inc_i,
  input wire logic clr_i,
  output logic [7:0] count_o,
  output logic half_o
);

  wire logic at_max;
  wire logic crossing;
  wire logic [7:0] next_count;

  // saturates at the top instead of wrapping
  assign at_max = (count_o == `PISC_FC_MAX); // RULE12
  assign crossing = ~clr_i & inc_i & (count_o == `PISC_FC_HALF); // RULE12
  assign next_count = clr_i ? {7'h00, inc_i} :
                      (inc_i & ~at_max) ? count_o + 8'h01 : count_o;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      count_o <= `PISC_FC_RST;
      half_o <= 1'b0;
    end
    else
    begin
      count_o <= next_count;
      half_o <= crossing;
    end
  end

endmodule : pisc_fc_cnt
`default_nettype wire

/* dv/pisc_props.sv */
`timescale 1ns/100ps
`default_nettype none
module pisc_props
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic int_pin_o,
  input wire logic irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_wait; psel_i && penable_i && !pready_o |=> pready_o; endproperty
  a_wait: assert property (p_wait) else $error("ready not after one wait");
  property p_early; psel_i && !penable_i |=> !pready_o; endproperty
  a_early: assert property (p_early) else $error("ready too early");
  property p_one; pready_o |=> !pready_o; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_nosel; !psel_i |=> !pready_o; endproperty
  a_nosel: assert property (p_nosel) else $error("ready without select");
  property p_err; pslverr_o |-> pready_o; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_errd; pready_o && pslverr_o |-> prdata_o == 32'h0; endproperty
  a_errd: assert property (p_errd) else $error("error with data");
  property p_hi; pready_o |-> prdata_o[31:16] == 16'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper half not zero");
  property p_rst; disable iff (1'b0) rst_i |=> !pready_o && !irq_o && int_pin_o; endproperty
  a_rst: assert property (p_rst) else $error("bad reset outputs");
endmodule : pisc_props
`default_nettype wire

/* dv/pisc_top_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module pisc_top_tb_top;
  import pisc_pkg::*;
  logic mclk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [7:0] paddr_i = 8'h0;
  logic [31:0] pwdata_i = 32'h0, prdata_o, r;
  logic [3:0] pstrb_i = 4'hF;
  pisc_evt_t evt_i = 8'h0;
  logic pready_o, pslverr_o, int_pin_o, irq_o, e;
  int fails = 0, total_checks = 0, cyc = 0;
  pisc_top uut (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i, .evt_i, .prdata_o, .pready_o, .pslverr_o, .int_pin_o, .irq_o);
  initial forever #2.5 mclk_i = ~mclk_i;
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fails++;
      tally_and_finish;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1;
    @(posedge mclk_i);
    while (pready_o !== 1'b1) @(posedge mclk_i);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    @(posedge mclk_i);
  endtask : apb
  task ev(input logic [7:0] v, input logic [7:0] x);
    evt_i <= v;
    @(posedge mclk_i);
    evt_i <= v & 8'hE0;
    repeat (3) @(posedge mclk_i);
    apb(0, 8'h48, 0);
    chk(r[15:8], x);
    apb(0, 8'h48, 0);
    chk(r[15:8], 8'h00);
  endtask : ev
  task t_reset;
    apb(0, 8'h44, 0);
    chk(r, 32'h010B);
    apb(0, 8'h48, 0);
    chk(r, 32'h0);
    apb(0, 8'h7C, 0);
    chk(e, 1'b1);
    apb(0, 8'h45, 0);
    chk(e, 1'b1);
    $display("reset done");
  endtask : t_reset
  task t_test;
    apb(1, 8'h44, 32'h010F);
    @(posedge mclk_i);
    chk(int_pin_o, 1'b0);
    apb(1, 8'h44, 32'h0107);
    @(posedge mclk_i);
    chk(int_pin_o, 1'b1);
    apb(1, 8'h44, 32'h0103);
    @(posedge mclk_i);
    chk(int_pin_o, 1'b0);
    apb(1, 8'h44, 32'h010B);
    @(posedge mclk_i);
    chk(int_pin_o, 1'b1);
    $display("test done");
  endtask : t_test
  task t_events;
    ev(8'h10, 8'h10);
    ev(8'h08, 8'h08);
    ev(8'h04, 8'h04);
    ev(8'h01, 8'h01);
    ev(8'h80, 8'h20);
    ev(8'hC0, 8'h80);
    ev(8'hE0, 8'h40);
    ev(8'h60, 8'h20);
    ev(8'h20, 8'h00);
    ev(8'h00, 8'h40);
    $display("events done");
  endtask : t_events
  task t_irq;
    apb(1, 8'h60, 32'hFF);
    apb(1, 8'h64, 32'h08);
    apb(1, 8'h48, 32'hFF08);
    apb(0, 8'h48, 0);
    chk(r[15:0], 16'h0008);
    ev(8'h10, 8'h10);
    chk({int_pin_o, irq_o}, 2'b10);
    evt_i <= 8'h08;
    @(posedge mclk_i);
    evt_i <= 8'h00;
    repeat (3) @(posedge mclk_i);
    chk({int_pin_o, irq_o}, 2'b01);
    apb(0, 8'h60, 0);
    chk(r[7:0], 8'h18);
    apb(1, 8'h60, 32'h18);
    @(posedge mclk_i);
    chk(irq_o, 1'b0);
    apb(0, 8'h48, 0);
    chk(r[15:8], 8'h08);
    @(posedge mclk_i);
    chk(int_pin_o, 1'b1);
    $display("irq done");
  endtask : t_irq
  task fc(input int n, input logic [7:0] x);
    evt_i <= 8'h02;
    repeat (n) @(posedge mclk_i);
    evt_i <= 8'h00;
    repeat (3) @(posedge mclk_i);
    apb(0, 8'h48, 0);
    chk(r[15:8], x);
  endtask : fc
  task t_fc;
    fc(127, 8'h00);
    fc(1, 8'h02);
    apb(0, 8'h50, 0);
    chk(r, 32'h80);
    fc(300, 8'h02);
    apb(0, 8'h50, 0);
    chk(r, 32'hFF);
    $display("counter done");
  endtask : t_fc
  initial
  begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 0;
    @(posedge mclk_i);
    t_reset;
    t_test;
    t_events;
    t_irq;
    t_fc;
    tally_and_finish;
  end
endmodule : pisc_top_tb_top
bind pisc_top pisc_props u_props (.mclk_i, .rst_i, .psel_i, .penable_i, .prdata_o,
  .pready_o, .pslverr_o, .int_pin_o, .irq_o);
`default_nettype wire
